// ===== inc/scg_pkg.sv
package scg_pkg;

  // register bus geometry
  localparam int          ADDR_W       = 10;
  localparam int          DATA_W       = 32;
  localparam int          IDX_LSB      = 2;

  // register indices, byte address is four times the index
  localparam logic [7:0]  IDX_DIVCTL   = 8'h61;
  localparam logic [7:0]  IDX_TRIM     = 8'h66;
  localparam logic [7:0]  IDX_SLEEP    = 8'h53;
  localparam logic [7:0]  IDX_STATUS   = 8'h54;

  // divider control fields
  localparam int          UNLOCK_BIT   = 7;
  localparam logic [7:0]  UNLOCK_WORD  = 8'h80;
  localparam logic [7:0]  DIVCTL_MASK  = 8'h8f;
  localparam logic [3:0]  SEL_DIV1     = 4'h0;
  localparam logic [3:0]  SEL_DIV8     = 4'h3;
  localparam logic [3:0]  SEL_MAX      = 4'h8;
  localparam logic [2:0]  UNLOCK_LAST  = 3'h3;

  // sleep control fields
  localparam int          ALLOW_BIT    = 0;
  localparam int          MODE_LO      = 1;
  localparam int          MODE_HI      = 3;
  localparam int          PEND_BIT     = 4;
  localparam logic [2:0]  MODE_IDLE    = 3'h0;
  localparam logic [2:0]  MODE_ADC     = 3'h1;
  localparam logic [2:0]  MODE_PDOWN   = 3'h2;
  localparam logic [2:0]  MODE_PSAVE   = 3'h3;
  localparam logic [2:0]  MODE_STBY    = 3'h6;

  // wake timing in clock cycles
  localparam logic [2:0]  STARTUP_CK   = 3'h6;
  localparam logic [2:0]  HOLD_CK      = 3'h4;

  // gate vector order: cpu flash io adc asy main tosc
  localparam int          G_CPU        = 6;
  localparam int          G_FLASH      = 5;
  localparam int          G_IO         = 4;
  localparam int          G_ADC        = 3;
  localparam int          G_ASY        = 2;
  localparam int          G_MAIN       = 1;
  localparam int          G_TOSC       = 0;
  localparam logic [6:0]  GATE_RUN     = 7'h7f;
  localparam logic [6:0]  GATE_IDLE    = 7'h1f;
  localparam logic [6:0]  GATE_ADC     = 7'h0f;
  localparam logic [6:0]  GATE_PDOWN   = 7'h00;
  localparam logic [6:0]  GATE_PSAVE   = 7'h05;
  localparam logic [6:0]  GATE_STBY    = 7'h02;
  localparam logic [6:0]  GATE_START   = 7'h03;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b10,
    ST_HOLD  = 2'b11
  } scg_state_t;

endpackage : scg_pkg

// ===== hdl/scg_prescaler.sv
`timescale 1ns/100ps
module scg_prescaler (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  // division select, sampled only at a period boundary
  input  wire logic [3:0] sel_i,
  // one master cycle per divided period
  output logic            tick_o
);

  logic [7:0] cnt_r;
  logic [3:0] eff_sel;
  logic [8:0] period;
  logic [8:0] reload9;

  // reserved codes fall back to the slowest divide
  assign eff_sel = (sel_i > scg_pkg::SEL_MAX) ? scg_pkg::SEL_MAX : sel_i;
  assign period  = 9'h001 << eff_sel;
  assign reload9 = period - 9'h001;
  assign tick_o  = (cnt_r == 8'h00);

  // new setting is loaded only when the old period ends, so
  // no short period can ever appear on the divided clock
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_r <= 8'h00;
    end else if (ce_i) begin
      if (tick_o) begin
        cnt_r <= reload9[7:0];
      end else begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  a_tick_reload: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    tick_o && ce_i |=> cnt_r == $past(reload9[7:0]))
    else $error("divider reload does not match division select");

  a_no_short_tick: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    tick_o && ce_i && sel_i != scg_pkg::SEL_DIV1 |=> !tick_o)
    else $error("divided clock period shorter than selected");

endmodule : scg_prescaler

// ===== hdl/scg_wake_qual.sv
`timescale 1ns/100ps
module scg_wake_qual (
  // selected sleep mode and async state
  input  wire logic [2:0] mode_i,
  input  wire logic       async_run_i,
  // interrupt sources
  input  wire logic       external_interrupt_zero_level_i,
  input  wire logic       external_interrupt_zero_edge_i,
  input  wire logic       pin_change_i,
  input  wire logic       usi_start_i,
  input  wire logic       lcd_irq_i,
  input  wire logic       tmr2_irq_i,
  input  wire logic       spm_ready_i,
  input  wire logic       adc_done_i,
  input  wire logic       other_irq_i,
  // qualified wake request
  output logic            wake_o
);

  logic any_src;
  logic deep_src;
  logic adc_src;
  logic save_src;
  logic is_idle;
  logic is_adc;
  logic is_save;

  // edge on external_interrupt_zero only counts in idle; deeper modes need level
  assign deep_src = external_interrupt_zero_level_i | pin_change_i | usi_start_i;
  assign any_src  = deep_src | external_interrupt_zero_edge_i | lcd_irq_i | tmr2_irq_i |
                    spm_ready_i | adc_done_i | other_irq_i;
  assign adc_src  = deep_src | spm_ready_i | adc_done_i |
                    (async_run_i & (lcd_irq_i | tmr2_irq_i));
  assign save_src = deep_src | lcd_irq_i | tmr2_irq_i;

  // mode decode
  assign is_idle  = (mode_i == scg_pkg::MODE_IDLE);
  assign is_adc   = (mode_i == scg_pkg::MODE_ADC);
  assign is_save  = (mode_i == scg_pkg::MODE_PSAVE);
  assign wake_o   = is_idle ? any_src :
                    is_adc  ? adc_src :
                    is_save ? save_src : deep_src;

endmodule : scg_wake_qual

// ===== hdl/scg_clock_ctrl.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
module scg_clock_ctrl (
  // clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // factory straps
  input  wire logic [7:0]  factory_trim_i,
  input  wire logic        divide_by_eight_fuse_i,
  // cpu side
  input  wire logic        sleep_instr_i,
  input  wire logic        async_running_i,
  // wake sources
  input  wire logic        external_interrupt_zero_level_i,
  input  wire logic        external_interrupt_zero_edge_i,
  input  wire logic        pin_change_i,
  input  wire logic        usi_start_i,
  input  wire logic        lcd_irq_i,
  input  wire logic        tmr2_irq_i,
  input  wire logic        spm_ready_i,
  input  wire logic        adc_done_i,
  input  wire logic        other_irq_i,
  // oscillator trim
  output logic [7:0]       rc_oscillator_trim_o,
  output logic             trim_range_select_o,
  output logic [6:0]       trim_fine_value_o,
  // clock domain ticks and enables
  output logic             clk_cpu_tick_o,
  output logic             clk_flash_tick_o,
  output logic             clk_io_tick_o,
  output logic             clk_adc_tick_o,
  output logic             clk_asy_en_o,
  output logic             main_osc_en_o,
  output logic             timer_osc_en_o,
  // cpu sequencing
  output logic             cpu_halt_o,
  output logic             wake_irq_o
);

  // registers
  logic [7:0]        trim_r;
  logic              unlock_r;
  logic [2:0]        unlock_cnt_r;
  logic [3:0]        sel_r;
  logic              allow_r;
  logic [2:0]        mode_sel_r;
  logic [2:0]        mode_r;
  logic              ack_r;
  logic [31:0]       rdata_r;
  logic [6:0]        gate_r;
  logic [2:0]        wait_r;
  logic              wake_irq_r;
  scg_pkg::scg_state_t state_r;

  // next values
  scg_pkg::scg_state_t state_nxt;
  logic [2:0]        wait_nxt;
  logic [6:0]        gate_nxt;

  // decode wires
  logic              req;
  logic              done;
  logic              wr_en;
  logic [7:0]        idx;
  logic [7:0]        wd;
  logic              wr_div;
  logic              wr_trim;
  logic              wr_sleep;
  logic              unlock_set;
  logic              sel_take;
  logic              unlock_end;
  logic [7:0]        rd_mux;
  logic [7:0]        div_view;
  logic [7:0]        sleep_view;
  logic [7:0]        status_view;
  logic              mode_ok;
  logic              sleep_go;
  logic              wake;
  logic              tick;
  logic [6:0]        mode_gate;
  logic [6:0]        gate_eff;

  // bus handshake: every access waits exactly one cycle while ce_i is high
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~(ack_r & ce_i);
  assign done              = req & ack_r & ce_i;
  assign wr_en             = avs_write_i & done & avs_byteenable_i[0];
  assign idx               = avs_address_i[scg_pkg::IDX_LSB +: 8];
  assign wd                = avs_writedata_i[7:0];
  assign wr_div            = wr_en & (idx == scg_pkg::IDX_DIVCTL);
  assign wr_trim           = wr_en & (idx == scg_pkg::IDX_TRIM);
  assign wr_sleep          = wr_en & (idx == scg_pkg::IDX_SLEEP);

  // timed unlock sequence
  assign unlock_set = wr_div & (wd == scg_pkg::UNLOCK_WORD) & ~unlock_r;
  assign sel_take   = wr_div & unlock_r & ~wd[scg_pkg::UNLOCK_BIT];
  assign unlock_end = unlock_r & (unlock_cnt_r == scg_pkg::UNLOCK_LAST);

  // register read views; unused bits read zero
  assign div_view    = {unlock_r, 3'h0, sel_r} & scg_pkg::DIVCTL_MASK;
  assign sleep_view  = {4'h0, mode_sel_r, allow_r};
  assign status_view = {3'h0, unlock_r, mode_r, (state_r != scg_pkg::ST_RUN)};
  assign rd_mux = (idx == scg_pkg::IDX_DIVCTL) ? div_view    :
                  (idx == scg_pkg::IDX_TRIM)   ? trim_r      :
                  (idx == scg_pkg::IDX_SLEEP)  ? sleep_view  :
                  (idx == scg_pkg::IDX_STATUS) ? status_view : 8'h00;

  // bus acknowledge and read data capture
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        rdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end
  assign avs_readdata_o = rdata_r;

  // trim register; strap caught by the synchronous reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      trim_r <= factory_trim_i;
    end else if (ce_i && wr_trim) begin
      trim_r <= wd;
    end
  end
  assign rc_oscillator_trim_o = trim_r;
  assign trim_range_select_o  = trim_r[7];
  assign trim_fine_value_o    = trim_r[6:0];

  // divider control: unlock flag, its timer and the select field
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 3'h0;
      sel_r        <= divide_by_eight_fuse_i ? scg_pkg::SEL_DIV8
                                             : scg_pkg::SEL_DIV1;
    end else if (ce_i) begin
      if (unlock_set) begin
        unlock_r     <= 1'b1;
        unlock_cnt_r <= 3'h0;
      end else if (sel_take || unlock_end) begin
        unlock_r     <= 1'b0;
      end else if (unlock_r) begin
        unlock_cnt_r <= unlock_cnt_r + 3'h1;
      end
      if (sel_take) begin
        sel_r <= wd[3:0];
      end
    end
  end

  // sleep mode control register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      allow_r    <= 1'b0;
      mode_sel_r <= scg_pkg::MODE_IDLE;
    end else if (ce_i && wr_sleep) begin
      allow_r    <= wd[scg_pkg::ALLOW_BIT];
      mode_sel_r <= wd[scg_pkg::MODE_HI:scg_pkg::MODE_LO];
    end
  end

  // only the five defined codes put the part to sleep
  assign mode_ok  = (mode_sel_r == scg_pkg::MODE_IDLE)  |
                    (mode_sel_r == scg_pkg::MODE_ADC)   |
                    (mode_sel_r == scg_pkg::MODE_PDOWN) |
                    (mode_sel_r == scg_pkg::MODE_PSAVE) |
                    (mode_sel_r == scg_pkg::MODE_STBY);
  assign sleep_go = sleep_instr_i & allow_r & mode_ok;

  // wake qualification per mode
  scg_wake_qual u_wake (
    .mode_i       (mode_r),
    .async_run_i  (async_running_i),
    .external_interrupt_zero_level_i (external_interrupt_zero_level_i),
    .external_interrupt_zero_edge_i  (external_interrupt_zero_edge_i),
    .pin_change_i (pin_change_i),
    .usi_start_i  (usi_start_i),
    .lcd_irq_i    (lcd_irq_i),
    .tmr2_irq_i   (tmr2_irq_i),
    .spm_ready_i  (spm_ready_i),
    .adc_done_i   (adc_done_i),
    .other_irq_i  (other_irq_i),
    .wake_o       (wake)
  );

  // gate pattern of the latched mode
  assign mode_gate = (mode_r == scg_pkg::MODE_IDLE)  ? scg_pkg::GATE_IDLE  :
                     (mode_r == scg_pkg::MODE_ADC)   ? scg_pkg::GATE_ADC   :
                     (mode_r == scg_pkg::MODE_PSAVE) ? scg_pkg::GATE_PSAVE :
                     (mode_r == scg_pkg::MODE_STBY)  ? scg_pkg::GATE_STBY  :
                     scg_pkg::GATE_PDOWN;

  // sleep sequencer; start-up only when the oscillator was stopped
  always_comb begin
    state_nxt = state_r;
    wait_nxt  = wait_r;
    gate_nxt  = gate_r;
    unique case (state_r)
      scg_pkg::ST_RUN: begin
        gate_nxt = scg_pkg::GATE_RUN;
        // cpu and flash stop on the entry edge; mode gates follow
        if (sleep_go) begin
          state_nxt = scg_pkg::ST_SLEEP;
          gate_nxt  = scg_pkg::GATE_IDLE;
        end
      end
      scg_pkg::ST_SLEEP: begin
        gate_nxt = mode_gate;
        if (wake) begin
          if (mode_gate[scg_pkg::G_MAIN]) begin
            state_nxt = scg_pkg::ST_HOLD;
            wait_nxt  = scg_pkg::HOLD_CK - 3'h1;
            gate_nxt  = scg_pkg::GATE_IDLE;
          end else begin
            state_nxt = scg_pkg::ST_START;
            wait_nxt  = scg_pkg::STARTUP_CK - 3'h1;
            gate_nxt  = scg_pkg::GATE_START;
          end
        end
      end
      scg_pkg::ST_START: begin
        if (wait_r == 3'h0) begin
          state_nxt = scg_pkg::ST_HOLD;
          wait_nxt  = scg_pkg::HOLD_CK - 3'h1;
          gate_nxt  = scg_pkg::GATE_IDLE;
        end else begin
          wait_nxt = wait_r - 3'h1;
        end
      end
      scg_pkg::ST_HOLD: begin
        if (wait_r == 3'h0) begin
          state_nxt = scg_pkg::ST_RUN;
          gate_nxt  = scg_pkg::GATE_RUN;
        end else begin
          wait_nxt = wait_r - 3'h1;
        end
      end
    endcase
  end

  // state registers; wake never touches cpu storage, only clocks
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r    <= scg_pkg::ST_RUN;
      wait_r     <= 3'h0;
      gate_r     <= scg_pkg::GATE_RUN;
      mode_r     <= scg_pkg::MODE_IDLE;
      wake_irq_r <= 1'b0;
    end else if (ce_i) begin
      state_r    <= state_nxt;
      wait_r     <= wait_nxt;
      gate_r     <= gate_nxt;
      wake_irq_r <= (state_r == scg_pkg::ST_HOLD) &&
                    (state_nxt == scg_pkg::ST_RUN);
      if (sleep_go && state_r == scg_pkg::ST_RUN) begin
        mode_r <= mode_sel_r;
      end
    end
  end

  // divided clock source
  scg_prescaler u_div (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .sel_i     (sel_r),
    .tick_o    (tick)
  );

  // timer oscillator runs only for an asynchronous unit
  assign gate_eff = {gate_r[6:1], gate_r[scg_pkg::G_TOSC] & async_running_i};

  // the divided tick feeds every synchronous domain
  assign clk_cpu_tick_o   = tick & gate_eff[scg_pkg::G_CPU];
  assign clk_flash_tick_o = tick & gate_eff[scg_pkg::G_FLASH];
  assign clk_io_tick_o    = tick & gate_eff[scg_pkg::G_IO];
  assign clk_adc_tick_o   = tick & gate_eff[scg_pkg::G_ADC];
  assign clk_asy_en_o     = gate_eff[scg_pkg::G_ASY];
  assign main_osc_en_o    = gate_eff[scg_pkg::G_MAIN];
  assign timer_osc_en_o   = gate_eff[scg_pkg::G_TOSC];
  assign cpu_halt_o       = (state_r != scg_pkg::ST_RUN);
  assign wake_irq_o       = wake_irq_r;

  // multi-step checks
  sequence s_hold_four;
    (state_r == scg_pkg::ST_HOLD)[*4] ##1 (state_r == scg_pkg::ST_RUN);
  endsequence

  a_trim_reset: assert property (@(posedge mclk_i)
    sys_rst_i |=> trim_r == $past(factory_trim_i))
    else $error("trim not loaded from factory value at reset");

  a_sel_reset: assert property (@(posedge mclk_i)
    sys_rst_i |=> sel_r == ($past(divide_by_eight_fuse_i) ?
                  scg_pkg::SEL_DIV8 : scg_pkg::SEL_DIV1))
    else $error("division select reset value wrong");

  a_unlock_cause: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(unlock_r) |-> $past(wr_div && wd == scg_pkg::UNLOCK_WORD))
    else $error("unlock set without exact unlock write");

  a_unlock_limit: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i || !ce_i)
    $rose(unlock_r) |-> ##[1:4] !unlock_r)
    else $error("unlock stayed open beyond four cycles");

  a_unlock_steady: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i || !ce_i)
    unlock_r && wr_div && wd[scg_pkg::UNLOCK_BIT] && !unlock_end
    |=> unlock_r && unlock_cnt_r == $past(unlock_cnt_r) + 3'h1)
    else $error("unlock rewrite restarted or cleared window");

  a_sel_window: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sel_r != $past(sel_r) |-> $past(unlock_r && wr_div))
    else $error("division select changed outside unlock window");

  a_sleep_entry: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state_r == scg_pkg::ST_SLEEP && $past(state_r) == scg_pkg::ST_RUN
    |-> $past(allow_r && sleep_instr_i))
    else $error("sleep entered without sleep allow");

  a_hold_four: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i || !ce_i)
    $rose(state_r == scg_pkg::ST_HOLD) |-> s_hold_four)
    else $error("wake halt not exactly four cycles");

  a_cpu_gated: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state_r != scg_pkg::ST_RUN |-> !clk_cpu_tick_o && !clk_flash_tick_o)
    else $error("cpu clock running while asleep");

  a_pdown_dark: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state_r == scg_pkg::ST_SLEEP && mode_r == scg_pkg::MODE_PDOWN
    && $past(state_r) == scg_pkg::ST_SLEEP |-> gate_r == scg_pkg::GATE_PDOWN)
    else $error("power-down left a clock running");

  a_reserved_zero: assert property (@(posedge mclk_i)
    div_view[6:4] == 3'h0)
    else $error("reserved divider bits not zero");

endmodule : scg_clock_ctrl

// ===== testbench/scg_cpu_model.sv
`timescale 1ns/100ps
// cpu stand-in: register bus master plus the sleep instruction
module scg_cpu_model (
  // clock and bus answer
  input  wire logic        mclk_i,
  input  wire logic        wt_i,
  input  wire logic [31:0] rd_i,
  // bus request and sleep pulse
  output logic [9:0]       adr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic [31:0]      wd_o,
  output logic             slp_o
);
  // idle bus at time zero
  initial begin
    adr_o = 10'h000;
    rd_o  = 1'b0;
    wr_o  = 1'b0;
    wd_o  = 32'h0;
    slp_o = 1'b0;
  end

  // one transfer, held until waitrequest is seen low at an edge
  // no interrupt exists here, so a two-write unlock is never split
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
            output logic [31:0] q);
    @(posedge mclk_i);
    adr_o <= {idx, 2'b00};
    wd_o  <= {24'h0, d};
    wr_o  <= w;
    rd_o  <= ~w;
    @(posedge mclk_i);
    while (wt_i !== 1'b0) @(posedge mclk_i);
    q = rd_i;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  endtask : xfer

  // sleep instruction, one cycle, issued whether or not allow was written
  task sleep_op;
    @(posedge mclk_i);
    slp_o <= 1'b1;
    @(posedge mclk_i);
    slp_o <= 1'b0;
  endtask : sleep_op
endmodule : scg_cpu_model

// ===== testbench/tb_scg_clock_ctrl.sv
`timescale 1ns/100ps
// self-checking bench for the clock and sleep controller
module tb_scg_clock_ctrl;
  logic        mclk_i    = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        fuse      = 1'b1;
  logic        asyn      = 1'b1;
  logic [8:0]  irq       = 9'h000;
  logic [15:0] lf        = 16'h5b13;
  logic [7:0]  ftrim;
  logic [9:0]  adr;
  logic        rd;
  logic        wr;
  logic        sl;
  logic        wt;
  logic        rng;
  logic        halt;
  logic        wirq;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [7:0]  trim;
  logic [7:0]  tw;
  logic [6:0]  fine;
  logic [6:0]  gv;
  logic [3:0]  s;
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  int          n;
  int          op;
  int          np;
  // per mode: code, gates, wake source, halt length
  logic [2:0]  md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic [6:0]  eg [5] = '{7'h1f, 7'h0f, 7'h00, 7'h05, 7'h02};
  logic [8:0]  ws [5] = '{9'h001, 9'h010, 9'h100, 9'h008, 9'h020};
  int          ew [5] = '{4, 4, 10, 10, 4};

  scg_cpu_model scg_cpu_model_inst (.mclk_i(mclk_i), .wt_i(wt),
    .rd_i(rdat), .adr_o(adr), .rd_o(rd), .wr_o(wr), .wd_o(wd), .slp_o(sl));

  scg_clock_ctrl scg_clock_ctrl_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .factory_trim_i(ftrim),
    .divide_by_eight_fuse_i(fuse), .sleep_instr_i(sl),
    .async_running_i(asyn), .external_interrupt_zero_level_i(irq[8]), .external_interrupt_zero_edge_i(irq[7]),
    .pin_change_i(irq[6]), .usi_start_i(irq[5]), .lcd_irq_i(irq[4]),
    .tmr2_irq_i(irq[3]), .spm_ready_i(irq[2]), .adc_done_i(irq[1]),
    .other_irq_i(irq[0]), .rc_oscillator_trim_o(trim),
    .trim_range_select_o(rng), .trim_fine_value_o(fine),
    .clk_cpu_tick_o(gv[6]), .clk_flash_tick_o(gv[5]), .clk_io_tick_o(gv[4]),
    .clk_adc_tick_o(gv[3]), .clk_asy_en_o(gv[2]), .main_osc_en_o(gv[1]),
    .timer_osc_en_o(gv[0]), .cpu_halt_o(halt), .wake_irq_o(wirq));

  // clock and a hang guard well above the expected run
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  function logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      $display("BAD %0t got %h want %h", $time, g, e);
      n_mismatch++;
    end
  endtask : chk

  task reg_wr(input logic [7:0] i, input logic [7:0] d);
    scg_cpu_model_inst.xfer(1'b1, i, d, q);
  endtask : reg_wr

  task reg_rd(input logic [7:0] i);
    scg_cpu_model_inst.xfer(1'b0, i, 8'h00, q);
  endtask : reg_rd

  // cycles from one cpu tick to the next, bounded
  task gap(output int k);
    int g;
    g = 0;
    k = 0;
    @(posedge mclk_i);
    while (gv[6] !== 1'b1 && g < 600) begin
      @(posedge mclk_i);
      g++;
    end
    do begin
      @(posedge mclk_i);
      k++;
    end while (gv[6] !== 1'b1 && k < 600);
  endtask : gap

  task report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    ftrim = lf[7:0];
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk(trim, ftrim);
    reg_rd(scg_pkg::IDX_DIVCTL);
    chk(q, 32'h3);
    // random trims, split into range and fine fields
    repeat (4) begin
      lf = lfsr(lf);
      reg_wr(scg_pkg::IDX_TRIM, lf[7:0]);
      tw = lf[7:0];
      @(negedge mclk_i);
      chk({rng, fine, trim}, {lf[7:0], lf[7:0]});
    end
    // refused unlocks: extra bits, timeout, rewrite without restart
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h81);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h05);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h80);
    repeat (4) @(posedge mclk_i);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h05);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h80);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h80);
    reg_wr(8'h00, 8'h44);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h05);
    reg_rd(scg_pkg::IDX_DIVCTL);
    chk(q, 32'h3);
    reg_rd(8'h00);
    chk(q, 32'h0);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h80);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h80);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h02);
    reg_rd(scg_pkg::IDX_DIVCTL);
    chk(q, 32'h3);
    // every select code, one reserved code last
    op = 8;
    for (int c = 0; c < 10; c++) begin
      lf = lfsr(lf);
      s = (c < 9) ? c[3:0] : {1'b1, lf[2:0] | 3'h1};
      np = 1 << ((c < 9) ? c : 8);
      reg_wr(scg_pkg::IDX_DIVCTL, 8'h80);
      reg_wr(scg_pkg::IDX_DIVCTL, {4'h0, s});
      reg_rd(scg_pkg::IDX_DIVCTL);
      chk(q, {28'h0, s});
      gap(n);
      chk(n >= ((op < np) ? op : np), 1'b1);
      gap(n);
      chk(n, np);
      op = np;
    end
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h80);
    reg_wr(scg_pkg::IDX_DIVCTL, 8'h00);
    gap(n);
    gap(n);
    chk(n, 1);
    // sleep instruction without allow is ignored
    scg_cpu_model_inst.sleep_op();
    repeat (3) @(negedge mclk_i);
    chk(halt, 1'b0);
    // each mode: gating, a non-waking source except in idle, then a real wake
    for (int m = 0; m < 5; m++) begin
      reg_wr(scg_pkg::IDX_SLEEP, {4'h0, md[m], 1'b1});
      scg_cpu_model_inst.sleep_op();
      repeat (4) @(negedge mclk_i);
      chk({halt, gv}, {1'b1, eg[m]});
      @(posedge mclk_i);
      irq <= (m > 0) ? 9'h080 : 9'h000;
      repeat (5) @(negedge mclk_i);
      chk(halt, 1'b1);
      @(posedge mclk_i);
      irq <= ws[m];
      n = 0;
      while (wirq !== 1'b1 && n < 40) begin
        @(negedge mclk_i);
        n++;
      end
      @(posedge mclk_i);
      irq <= 9'h000;
      chk(n >= ew[m] && n <= ew[m] + 4, 1'b1);
      chk({halt, trim}, {1'b0, tw});
    end
    // reset in mid-sleep, with new straps
    reg_wr(scg_pkg::IDX_SLEEP, 8'h05);
    scg_cpu_model_inst.sleep_op();
    repeat (3) @(posedge mclk_i);
    lf = lfsr(lf);
    ftrim <= lf[7:0];
    fuse <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk({halt, trim}, {1'b0, lf[7:0]});
    reg_rd(scg_pkg::IDX_DIVCTL);
    chk(q, 32'h0);
    report_and_stop();
  end
endmodule : tb_scg_clock_ctrl
